// file: sync_serial_multiword_io.sv
`timescale 1ns/1ps
// Contract
// (R1) Burst of one to eight 4/8-bit words
// (R2) Done interrupt after programmed word count shifted
// (R3) Word count changes only stopped or waiting
// (R4) Transmit drives LSB first after run set
// (R5) Buffer word loads shift register; empty signalled
// (R6) Internal-clock transmit waits until a write
// (R7) Any buffer write ends the wait
// (R8) External transmit without data sends dummy, ends
// (R9) Run cleared in transmit: finish word, drop active
// (R10) Abort ends at once, clears active
// (R11) Software stops and checks active before recount
// (R12) Receive stores words, interrupts when count arrives
// (R13) Internal receive waits until any buffer read
// (R14) External receive unread: drop word, stop
// (R15) Run cleared in receive: store word, end
// (R16) Abort in receive discards partial word
// (R17) Software recounts before reading during wait
// (R18) Mode change clears the buffer bank
// (R19) Duplex drives on leading, samples trailing
// (R20) Software reads all before writing in duplex
// (R21) Duplex internal waits until a transmit write
// (R22) Run cleared in duplex: finish word, end
// (R23) Count 000..111 selects one..eight buffers
// (R24) 4-bit mode uses low nibble, zero-fills upper
// (R25) Falling clock edge transmits, rising receives
// (R26) External shift clock synchronised, edges detected
module sync_serial_multiword_io
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire sio_pkg::apb_req_t     apb_req,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  sck_in,
  input  wire logic                  si,
  output sio_pkg::serial_pins_t      pins,
  output logic                       serial_done_irq,
  output logic                       transfer_active_flag
);
  import sio_pkg::*;

  core_t r;
  core_t n;

  logic       setup;
  logic       access;
  logic       is_bank;
  logic       mapped;
  logic [2:0] widx;
  logic       fall;
  logic       rise;
  logic [2:0] last_bit;
  logic [7:0] shifted;
  logic       ok;

  always_comb
  begin
    n = r;
    n.done_irq = 1'b0;
    n.sck_sync = {r.sck_sync[1:0], sck_in}; // (R26)
    n.si_sync = {r.si_sync[0], si};
    setup = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable;
    widx = apb_req.paddr[4:2];
    is_bank = (apb_req.paddr[7:5] == BANK_PAGE) &&
              (apb_req.paddr[1:0] == 2'h0);
    mapped = is_bank || apb_req.paddr == OFF_CTRL_A ||
             apb_req.paddr == OFF_CTRL_B || apb_req.paddr == OFF_STATUS;
    last_bit = r.w8 ? LAST_BIT_W8 : LAST_BIT_W4; // (R1)
    // 4-bit words shift into the low nibble only
    shifted = r.w8 ? {r.si_sync[1], r.sh[7:1]}
                   : {4'h0, r.si_sync[1], r.sh[3:1]}; // (R24)
    ok = (r.mode == MODE_RX) ? r.rd_seen : r.wr_seen; // (R13) (R21)
    fall = 1'b0;
    rise = 1'b0;

    case (r.seq)
      SEQ_IDLE:
      begin
        n.sck = SCK_IDLE_RST;
      end
      SEQ_SHIFT:
      begin
        if (!r.ext_clk)
        begin
          n.div = r.div + 8'h01;
          if (r.div == SCK_HALF_CYC - 8'h01)
          begin
            n.div = 8'h00;
            n.sck = ~r.sck;
            fall = r.sck;
            rise = ~r.sck;
          end
        end
        else
        begin
          // Only the second and third stages feed the edge detector
          fall = r.sck_sync[2] & ~r.sck_sync[1]; // (R26)
          rise = ~r.sck_sync[2] & r.sck_sync[1];
        end
        if (fall && r.mode != MODE_RX)
          n.so = r.sh[0]; // (R4) (R19) (R25)
        if (rise)
        begin
          n.sh = shifted; // (R25)
          n.bit_idx = r.bit_idx + 3'h1;
          if (r.bit_idx == last_bit)
          begin
            n.bit_idx = 3'h0;
            if (r.mode != MODE_TX && !r.last_dummy)
              n.bank[r.word_idx] = shifted; // (R12) (R14) (R15) (R22)
            if (r.word_idx == r.cnt && !r.last_dummy)
              n.done_irq = 1'b1; // (R2) (R5) (R12)
            if (r.last_dummy || !r.run)
            begin
              n.seq = SEQ_IDLE; // (R8) (R9) (R14) (R15) (R22)
              n.active = 1'b0;
              n.last_dummy = 1'b0;
            end
            else if (r.word_idx != r.cnt)
            begin
              n.word_idx = r.word_idx + 3'h1; // (R23)
              n.sh = r.bank[r.word_idx + 3'h1]; // (R5)
            end
            else
            begin
              n.word_idx = 3'h0;
              n.sh = r.bank[0];
              if (ok)
              begin
                n.wr_seen = 1'b0;
                n.rd_seen = 1'b0;
              end
              else if (!r.ext_clk)
                n.seq = SEQ_WAIT; // (R6) (R13) (R21)
              else
                n.last_dummy = 1'b1; // (R8) (R14)
            end
          end
        end
      end
      SEQ_WAIT:
      begin
        n.sck = SCK_IDLE_RST;
        if (!r.run)
        begin
          n.seq = SEQ_IDLE;
          n.active = 1'b0;
        end
        else if (ok)
        begin
          // Recount may have happened during the wait; restart at 0
          n.seq = SEQ_SHIFT; // (R6) (R7) (R13)
          n.div = 8'h00;
          n.sh = r.bank[0];
          n.wr_seen = 1'b0;
          n.rd_seen = 1'b0;
        end
      end
      default:
      begin
        n.seq = SEQ_IDLE;
        n.active = 1'b0;
      end
    endcase

    // Register bus side; applied last so bus events win over clears
    if (setup)
    begin
      n.pslverr = ~mapped;
      n.prdata = 32'h0;
      if (is_bank)
        n.prdata = {24'h0, r.bank[widx]};
      else if (apb_req.paddr == OFF_CTRL_A)
      begin
        n.prdata[CA_RUN] = r.run;
        n.prdata[CA_MODE +: 2] = r.mode;
        n.prdata[CA_EXT] = r.ext_clk;
        n.prdata[CA_W8] = r.w8;
      end
      else if (apb_req.paddr == OFF_CTRL_B)
        n.prdata[CB_CNT +: 3] = r.cnt;
      else if (apb_req.paddr == OFF_STATUS)
      begin
        n.prdata[SR_ACTIVE] = r.active;
        n.prdata[SR_WAIT] = (r.seq == SEQ_WAIT);
      end
    end

    if (access && apb_req.pwrite && mapped)
    begin
      if (is_bank)
      begin
        n.bank[widx] = apb_req.pwdata[7:0];
        n.wr_seen = 1'b1; // (R6) (R7) (R21)
      end
      else if (apb_req.paddr == OFF_CTRL_A)
      begin
        n.run = apb_req.pwdata[CA_RUN];
        n.ext_clk = apb_req.pwdata[CA_EXT];
        n.w8 = apb_req.pwdata[CA_W8];
        n.mode = dir_mode_t'(apb_req.pwdata[CA_MODE +: 2]);
        if (n.mode != r.mode)
          n.bank = '0; // (R18)
        if (apb_req.pwdata[CA_ABORT])
        begin
          // Partial word is dropped, nothing is stored
          n.seq = SEQ_IDLE; // (R10) (R16)
          n.active = 1'b0;
          n.run = 1'b0;
          n.last_dummy = 1'b0;
          n.bit_idx = 3'h0;
          // Park the clock high at once, not a cycle later
          n.sck = SCK_IDLE_RST;
          n.div = 8'h00;
        end
        else if (n.run && r.seq == SEQ_IDLE && n.mode != MODE_OFF)
        begin
          n.seq = SEQ_SHIFT; // (R4)
          n.active = 1'b1;
          n.word_idx = 3'h0;
          n.bit_idx = 3'h0;
          n.div = 8'h00;
          n.sck = SCK_IDLE_RST;
          n.sh = n.bank[0];
          n.wr_seen = 1'b0;
          n.rd_seen = 1'b0;
          n.last_dummy = 1'b0;
        end
      end
      else if (apb_req.paddr == OFF_CTRL_B)
      begin
        // Ignored mid-transfer unless parked in an internal wait
        if (!r.active || (r.seq == SEQ_WAIT && !r.ext_clk))
          n.cnt = apb_req.pwdata[CB_CNT +: 3]; // (R3) (R11) (R17)
      end
    end

    if (access && !apb_req.pwrite && is_bank)
      n.rd_seen = 1'b1; // (R13)

    n.oe_n = ~(n.active & ~n.ext_clk);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '0;
      r.sck <= SCK_IDLE_RST;
      r.oe_n <= OE_N_RST;
      r.cnt <= CNT_RST;
    end
    else
      r <= n;
  end

  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = r.pslverr;
  assign pins.sck_out = r.sck;
  assign pins.sck_oe_n = r.oe_n;
  assign pins.so = r.so;
  assign serial_done_irq = r.done_irq;
  assign transfer_active_flag = r.active;

endmodule

// file: sio_pkg.sv
package sio_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BANK   = 8'h20;
  localparam logic [2:0] BANK_PAGE  = 3'h1;

  // serial_ctrl_a field positions
  localparam int CA_RUN   = 0;
  localparam int CA_ABORT = 1;
  localparam int CA_MODE  = 2;
  localparam int CA_EXT   = 4;
  localparam int CA_W8    = 5;

  // serial_ctrl_b and serial_status_reg field positions
  localparam int CB_CNT    = 0;
  localparam int SR_ACTIVE = 0;
  localparam int SR_WAIT   = 1;

  // Reset values
  localparam logic       SCK_IDLE_RST = 1'b1;
  localparam logic       OE_N_RST     = 1'b1;
  localparam logic [2:0] CNT_RST      = 3'h0;

  // Internal shift clock half period in system clocks
  localparam logic [7:0] SCK_HALF_CYC = 8'h04;

  // Last bit index of a word
  localparam logic [2:0] LAST_BIT_W4 = 3'h3;
  localparam logic [2:0] LAST_BIT_W8 = 3'h7;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_TX,
    MODE_RX,
    MODE_TXRX
  } dir_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SHIFT,
    SEQ_WAIT
  } seq_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic sck_out;
    logic sck_oe_n;
    logic so;
  } serial_pins_t;

  typedef struct packed {
    logic [7:0][7:0] bank;
    seq_t            seq;
    dir_mode_t       mode;
    logic            run;
    logic            ext_clk;
    logic            w8;
    logic [2:0]      cnt;
    logic            active;
    logic [2:0]      word_idx;
    logic [2:0]      bit_idx;
    logic [7:0]      sh;
    logic [7:0]      div;
    logic            sck;
    logic            oe_n;
    logic            so;
    logic            wr_seen;
    logic            rd_seen;
    logic            last_dummy;
    logic            done_irq;
    logic [2:0]      sck_sync;
    logic [1:0]      si_sync;
    logic [31:0]     prdata;
    logic            pslverr;
  } core_t;

endpackage

// file: sio_monitor.sv
`timescale 1ns/1ps
module sio_monitor
  import sio_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire sio_pkg::apb_req_t     apb_req,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  sck_in,
  input wire logic                  si,
  input wire sio_pkg::serial_pins_t pins,
  input wire logic                  serial_done_irq,
  input wire logic                  transfer_active_flag
);
  logic wr_a;
  assign wr_a = apb_req.psel && apb_req.penable && apb_req.pwrite
    && apb_req.paddr == OFF_CTRL_A;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_IDLE_HI: assert property (!transfer_active_flag |-> pins.sck_out)
    else $error("shift clock low while idle");
  AST_OE: assert property (!pins.sck_oe_n |-> transfer_active_flag)
    else $error("clock driven while idle");
  AST_HALF: assert property ($fell(pins.sck_out) |=>
    (!pins.sck_out || !transfer_active_flag)[*3]
    ##1 (pins.sck_out || !transfer_active_flag))
    else $error("shift clock low phase not four cycles");
  AST_IRQ1: assert property (serial_done_irq |=> !serial_done_irq)
    else $error("done pulse longer than one cycle");
  AST_IRQ_ACT: assert property (serial_done_irq |->
    $past(transfer_active_flag))
    else $error("done pulse without a transfer");
  AST_IRQ_SCK: assert property (serial_done_irq |-> pins.sck_out)
    else $error("done pulse inside a word");
  AST_ABORT: assert property (wr_a && apb_req.pwdata[CA_ABORT] |=>
    !transfer_active_flag)
    else $error("abort left transfer active");
  AST_START: assert property (wr_a && apb_req.pwdata[CA_RUN]
    && !apb_req.pwdata[CA_ABORT] && apb_req.pwdata[3:2] != 2'h0
    && !transfer_active_flag |=> transfer_active_flag)
    else $error("run did not start a transfer");
endmodule
bind sync_serial_multiword_io sio_monitor sio_monitor_i (.clk(clk),
  .nrst(nrst), .apb_req(apb_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sck_in(sck_in), .si(si), .pins(pins),
  .serial_done_irq(serial_done_irq),
  .transfer_active_flag(transfer_active_flag));

// file: sio_peer.sv
`timescale 1ns/1ps
module sio_peer
(
  input wire logic sck,
  input wire logic so,
  input wire logic ext_en,
  output logic     sck_drv,
  output logic     si
);
  logic [7:0]  sh;
  logic [63:0] rx;
  initial
  begin
    sck_drv = 1'b1;
    si = 1'b0;
    sh = 8'h00;
    rx = 64'h0;
    #3;
    // Odd offset keeps it out of phase with clk; still between frames
    forever #40 sck_drv = ext_en ? ~sck_drv : 1'b1;
  end
  always @(negedge sck)
  begin
    si <= sh[0];
    sh <= {1'b0, sh[7:1]};
  end
  always @(posedge sck)
    rx <= {so, rx[63:1]};
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
  import sio_pkg::*;
  logic         clk, nrst, sck_in, si, irq, act, ext_en, pready;
  logic         pslverr, perr, sck_drv;
  logic [31:0]  prdata, rd;
  logic [7:0]   p;
  logic [7:0]   exp_q[$];
  apb_req_t     req;
  serial_pins_t pins;
  int           mismatches, checks_done;
  assign sck_in = pins.sck_oe_n ? sck_drv : pins.sck_out;
  sync_serial_multiword_io sync_serial_multiword_io_i (.clk(clk),
    .nrst(nrst), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_in(sck_in), .si(si), .pins(pins),
    .serial_done_irq(irq), .transfer_active_flag(act));
  sio_peer sio_peer_i (.sck(sck_in), .so(pins.so), .ext_en(ext_en),
    .sck_drv(sck_drv), .si(si));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("mismatches=%0d checks=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 50)
    begin
      mismatches++;
      print_verdict();
    end
    rd = prdata;
    perr = pslverr;
    req <= '0;
  endtask
  task wt(input logic want_irq);
    for (int n = 0; n < 3000; n++)
    begin
      @(posedge clk);
      if (want_irq ? irq === 1'b1 : act === 1'b0)
        return;
    end
    mismatches++;
    print_verdict();
  endtask
  task go(input logic [31:0] ca);
    apb(1'b1, OFF_CTRL_A, ca | 32'h1);
    wt(1'b1);
    apb(1'b1, OFF_CTRL_A, ca);
    wt(1'b0);
  endtask
  initial
  begin
    nrst = 1'b0;
    req = '0;
    ext_en = 1'b0;
    mismatches = 0;
    checks_done = 0;
    void'($urandom(95147));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], perr}, 32'h1);
    apb(1'b1, OFF_CTRL_A, 32'h24);
    for (int k = 0; k < 3; k++)
    begin
      exp_q.push_back(8'($urandom));
      apb(1'b1, OFF_BANK + 8'(4 * k), {24'h0, exp_q[k]});
    end
    apb(1'b1, OFF_CTRL_B, 32'h2);
    go(32'h24);
    for (int k = 0; k < 3; k++)
      chk(sio_peer_i.rx[40 + 8 * k +: 8], exp_q[k]);
    // Receive four bits, upper nibble must come back zero
    p = 8'($urandom);
    apb(1'b1, OFF_CTRL_A, 32'h08);
    apb(1'b1, OFF_CTRL_B, 32'h0);
    sio_peer_i.sh = p;
    go(32'h08);
    apb(1'b0, OFF_BANK, 32'h0);
    chk(rd, {28'h0, p[3:0]});
    apb(1'b1, OFF_CTRL_A, 32'h2c);
    exp_q[0] = 8'($urandom);
    apb(1'b1, OFF_BANK, {24'h0, exp_q[0]});
    p = 8'($urandom);
    sio_peer_i.sh = p;
    go(32'h2c);
    chk(sio_peer_i.rx[63:56], exp_q[0]);
    apb(1'b0, OFF_BANK, 32'h0);
    chk(rd, {24'h0, p});
    // External clock: second word arrives unread and is dropped
    apb(1'b1, OFF_CTRL_A, 32'h38);
    p = 8'($urandom);
    sio_peer_i.sh = p;
    apb(1'b1, OFF_CTRL_A, 32'h39);
    ext_en <= 1'b1;
    repeat (16) @(posedge sck_drv);
    ext_en <= 1'b0;
    wt(1'b0);
    apb(1'b0, OFF_BANK, 32'h0);
    chk(rd, {24'h0, p});
    apb(1'b1, OFF_CTRL_A, 32'h04);
    apb(1'b0, OFF_BANK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFF_CTRL_B, 32'h7);
    apb(1'b1, OFF_CTRL_A, 32'h25);
    repeat (30) @(posedge clk);
    apb(1'b1, OFF_CTRL_A, 32'h26);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[SR_ACTIVE], 32'h0);
    print_verdict();
  end
endmodule
